// ---- irc_pkg.sv ----
package irc_pkg;

  localparam int unsigned TICKS_PER_BIT = 16;
  localparam int unsigned FRAME_BITS = 10;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] ENC_PULSE_ARM = 4'h6;
  localparam logic [3:0] ENC_PULSE_DROP = 4'h9;
  localparam logic [3:0] DEC_DRIVE_TICK = 4'h3;
  localparam logic [3:0] ENC_LAST_BIT = 4'h9;
  localparam logic [3:0] DEC_END_BIT = 4'ha;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PULSE_LIMIT_NS = 4000;
  localparam int unsigned PULSE_LIMIT_CYC = PULSE_LIMIT_NS / CLK_PERIOD_NS;

  localparam logic HOST_OUT_RST = 1'b1;
  localparam logic OPT_OUT_RST = 1'b0;

  typedef enum logic [1:0] {
    IRC_IDLE,
    IRC_ENCODE,
    IRC_DECODE
  } irc_mode_e;

  typedef struct packed {
    logic tick;
    logic hostTx;
    logic optIn;
  } irc_pins_s;

endpackage : irc_pkg

// ---- irc_codec.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Sixteen oversample ticks make one bit.
// - Frame state advances on oversample clock ticks; the limiter counts clk_sys.
// - Frames: start, eight data, one stop.
// - Zero bit: low 7, high 3, low rest.
// - One bit: optical output low whole bit.
// - Limiter ends optical pulse after 4 us.
// - Low pulse at bit start decodes zero.
// - Input high whole bit decodes one.
// - Decoded bit held sixteen ticks on host.
// - Reset low forces optical output low.
// - Optical input low suppresses transmission; half duplex.
// - Encoder aligns to host start edge.
// - Decoder aligns to received start edge.
// - In reset host output high, optical low.
// - Optical pulse rises 7 ticks after edge.
// - Host output falls 4 ticks after input low.

module irc_codec
  import irc_pkg::*;
#(
  parameter int unsigned LIMIT_CYC = irc_pkg::PULSE_LIMIT_CYC
)(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic oversampleClock,
  input wire logic hostTxIn,
  input wire logic opticalPulseIn,
  output logic hostRxOut,
  output logic opticalPulseOut
);
  import irc_pkg::*;

  // Synchronisers and edge history
  irc_pins_s meta_q;
  irc_pins_s sync_q;
  logic tickPrev_q;
  logic hostPrev_q;
  logic optPrev_q;
  logic tick;

  // Frame sequencing shared by both directions
  irc_mode_e mode_q;
  logic [3:0] tickCnt_q;
  logic [3:0] bitCnt_q;

  // Encoder pulse and its limiter
  logic pulseWin_q;
  logic [9:0] limitCnt_q;
  logic limitHit;

  // Decoder bit capture
  logic lowSeen_q;

  // Output flops
  logic hostRx_q;
  logic optOut_q;

  // Both pins and the oversample clock are foreign to clk_sys
  // Reset values match idle pin levels so no false edge follows reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '{tick: 1'b0, hostTx: 1'b1, optIn: 1'b1};
      sync_q <= '{tick: 1'b0, hostTx: 1'b1, optIn: 1'b1};
    end
    else
    begin
      meta_q <= '{tick: oversampleClock, hostTx: hostTxIn, optIn: opticalPulseIn};
      sync_q <= meta_q;
    end
  end

  // Rising edge of the oversample clock times every bit; only the limiter counts clk_sys
  assign tick = sync_q.tick & ~tickPrev_q;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tickPrev_q <= 1'b0;
      hostPrev_q <= 1'b1;
      optPrev_q <= 1'b1;
    end
    else
    begin
      tickPrev_q <= sync_q.tick;
      // History moves only on ticks, so a glitch between ticks is no edge
      if (tick)
      begin
        hostPrev_q <= sync_q.hostTx;
        optPrev_q <= sync_q.optIn;
      end
    end
  end

  // One shared mode keeps the link half duplex; the encoder wins a tie
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= IRC_IDLE;
      tickCnt_q <= '0;
      bitCnt_q <= '0;
    end
    else if (tick)
    begin
      unique case (mode_q)
        IRC_IDLE:
        begin
          tickCnt_q <= '0;
          bitCnt_q <= '0;
          // A host start wins a tie: the host cannot see a collision
          if (hostPrev_q && !sync_q.hostTx)
            mode_q <= IRC_ENCODE;
          else if (optPrev_q && !sync_q.optIn)
            mode_q <= IRC_DECODE;
        end

        IRC_ENCODE:
        begin
          tickCnt_q <= tickCnt_q + 4'h1;
          if (tickCnt_q == TICK_LAST)
          begin
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == ENC_LAST_BIT)
              mode_q <= IRC_IDLE;
          end
        end

        IRC_DECODE:
        begin
          tickCnt_q <= tickCnt_q + 4'h1;
          if (tickCnt_q == TICK_LAST)
            bitCnt_q <= bitCnt_q + 4'h1;
          // Runs one bit past the stop bit so it is held a full period
          if (bitCnt_q == DEC_END_BIT && tickCnt_q == DEC_DRIVE_TICK)
            mode_q <= IRC_IDLE;
        end
      endcase
    end
  end

  // Encoder window: ticks 7 to 9 of a zero bit
  // Host level is sampled at tick 6 as the window opens, mid-bit, well away from its own bit edges
  // Limitation: pulse width follows tick spacing, so clock jitter skews it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pulseWin_q <= 1'b0;
    else if (mode_q != IRC_ENCODE)
      pulseWin_q <= 1'b0;
    else if (tick && tickCnt_q == ENC_PULSE_ARM)
      pulseWin_q <= ~sync_q.hostTx;
    else if (tick && tickCnt_q == ENC_PULSE_DROP)
      pulseWin_q <= 1'b0;
  end

  // Limiter counts clk_sys so slow baud rates do not waste emitter current
  // It saturates, so a long window cannot wrap and re-enable the pulse
  assign limitHit = (limitCnt_q >= LIMIT_CYC[9:0]);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      limitCnt_q <= '0;
    else if (!pulseWin_q)
      limitCnt_q <= '0;
    else if (!limitHit)
      limitCnt_q <= limitCnt_q + 10'h001;
  end

  // Gating by the live optical input keeps our echo off a busy link
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      optOut_q <= OPT_OUT_RST;
    else
      optOut_q <= pulseWin_q & ~limitHit & sync_q.optIn;
  end

  // Decoder: any low in ticks 0 to 3 of a bit makes it a zero
  // Limitation: a pulse that starts after tick 3 is not seen
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      lowSeen_q <= 1'b0;
    else if (mode_q == IRC_IDLE)
      lowSeen_q <= 1'b1;
    else if (tick)
    begin
      if (tickCnt_q == TICK_LAST)
        lowSeen_q <= ~sync_q.optIn;
      else
        lowSeen_q <= lowSeen_q | ~sync_q.optIn;
    end
  end

  // The extra bit after the stop bit returns the line to idle high
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      hostRx_q <= HOST_OUT_RST;
    else if (mode_q != IRC_DECODE)
      hostRx_q <= HOST_OUT_RST;
    else if (tick && tickCnt_q == DEC_DRIVE_TICK)
    begin
      if (bitCnt_q == DEC_END_BIT)
        hostRx_q <= HOST_OUT_RST;
      else
        hostRx_q <= ~lowSeen_q;
    end
  end

  // Pins come straight from flops so they never glitch
  assign hostRxOut = hostRx_q;
  assign opticalPulseOut = optOut_q;

endmodule : irc_codec

// ---- irc_codec_asserts.sv ----
`timescale 1ns/1ns
module irc_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hostTxIn,
  input wire logic opticalPulseIn,
  input wire logic hostRxOut,
  input wire logic opticalPulseOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_tx; $fell(hostTxIn) && hostRxOut; endsequence
  sequence s_rx; $fell(opticalPulseIn) && hostRxOut; endsequence
  sequence s_hi; opticalPulseOut[*8]; endsequence
  property p_rst; disable iff (1'b0) !nrst |-> hostRxOut && !opticalPulseOut; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_rise; s_tx |-> ##[52:76] $rose(opticalPulseOut); endproperty
  a_rise: assert property (p_rise) else $error("rise");
  property p_fall; s_rx |-> ##[32:48] $fell(hostRxOut); endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_wid; $rose(opticalPulseOut) |=> s_hi ##[1:20] !opticalPulseOut; endproperty
  a_wid: assert property (p_wid) else $error("width");
  property p_one; $rose(opticalPulseOut) |-> !$past(hostTxIn, 8); endproperty
  a_one: assert property (p_one) else $error("one");
  property p_gate; !opticalPulseIn[*4] |-> !opticalPulseOut; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_dup; !hostRxOut |-> !opticalPulseOut; endproperty
  a_dup: assert property (p_dup) else $error("duplex");
  property p_hold; $changed(hostRxOut) |=> $stable(hostRxOut)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule : irc_chk
bind irc_codec irc_chk u_chk (.clk_sys, .nrst, .hostTxIn, .opticalPulseIn, .hostRxOut,
  .opticalPulseOut);

// ---- irc_optic.sv ----
`timescale 1ns/1ns
module irc_optic (
  input wire logic oversampleClock,
  output logic opticalPulseIn
);
  initial opticalPulseIn = 1'b1;
  // Zero: three tick low pulse at bit start, one: high
  task automatic send(input logic [7:0] v);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge oversampleClock) opticalPulseIn = i == 9 || (i > 0 && v[i - 1]);
      repeat (3) @(negedge oversampleClock);
      opticalPulseIn = 1'b1;
      repeat (12) @(negedge oversampleClock);
    end
    repeat (8) @(negedge oversampleClock);
  endtask : send
endmodule : irc_optic

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic oversampleClock = 1'b0;
  logic tickRun = 1'b1;
  logic hostTxIn = 1'b1;
  logic opticalPulseIn;
  logic hostRxOut;
  logic opticalPulseOut;
  logic [7:0] expQ[$];
  logic [7:0] gotR;
  logic [7:0] gotT;
  logic [7:0] b;
  int failures = 0;
  int cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  // Tick at sixteen per bit, paused once after the third byte
  always #32 oversampleClock = tickRun ? ~oversampleClock : oversampleClock;
  irc_codec dut (.clk_sys, .nrst, .oversampleClock, .hostTxIn, .opticalPulseIn,
    .hostRxOut, .opticalPulseOut);
  irc_optic opt (.oversampleClock, .opticalPulseIn);
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // Host at the tick baud, LSB first
  task automatic hostSend(input logic [7:0] v);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_sys) #1 hostTxIn = i == 9 || (i > 0 && v[i - 1]);
      repeat (i == 9 ? 143 : 127) @(posedge clk_sys);
    end
  endtask : hostSend
  always
  begin
    @(negedge hostRxOut);
    repeat (64) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (128) @(posedge clk_sys);
      gotR[i] = hostRxOut;
    end
    chk("rx", gotR, expQ.pop_front());
  end
  always
  begin
    @(posedge opticalPulseOut);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (128) @(posedge clk_sys);
      gotT[i] = ~opticalPulseOut;
    end
    chk("tx", gotT, expQ.pop_front());
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'h5346f2ed));
    #1 nrst = 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("rst", {6'h00, hostRxOut, opticalPulseOut}, 8'h02);
    #1 nrst = 1'b1;
    repeat (20) @(posedge clk_sys);
    for (int k = 0; k < 5; k++)
    begin
      b = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
      expQ.push_back(b);
      hostSend(b);
      expQ.push_back(b);
      opt.send(b);
      if (k == 2)
      begin
        tickRun = 1'b0;
        repeat (200) @(posedge clk_sys);
        tickRun = 1'b1;
      end
    end
    // Host start during a decode is ignored
    expQ.push_back(8'h00);
    fork
      opt.send(8'h00);
      begin
        repeat (400) @(posedge clk_sys);
        #1 hostTxIn = 1'b0;
        repeat (128) @(posedge clk_sys);
        #1 hostTxIn = 1'b1;
      end
    join
    fork
      hostSend(8'h00);
    join_none
    repeat (70) @(posedge clk_sys);
    #1 nrst = 1'b0;
    @(posedge clk_sys);
    chk("midrst", {6'h00, hostRxOut, opticalPulseOut}, 8'h02);
    complete_run();
  end
endmodule : tb_top
